// [src/cfg_clk_pkg.sv]
// Constants for the configuration word decoder and clock selector.
package cfg_clk_pkg;
    localparam logic [15:0] CFG_WORD_ONE_ADDR = 16'h8007;
    localparam logic [15:0] CFG_WORD_TWO_ADDR = 16'h8008;
    localparam int CFG_WIDTH = 14;
    localparam int FAILSAFE_BIT = 13;
    localparam int SWITCHOVER_BIT = 12;
    localparam int CLOCK_OUT_PIN_BIT = 11;
    localparam int BROWNOUT_HI = 10;
    localparam int BROWNOUT_LO = 9;
    localparam int DATA_PROT_BIT = 8;
    localparam int PROG_PROT_BIT = 7;
    localparam int RESET_PIN_BIT = 6;
    localparam int POWERUP_BIT = 5;
    localparam int WATCHDOG_HI = 4;
    localparam int WATCHDOG_LO = 3;
    localparam int OSC_HI = 2;
    localparam int OSC_LO = 0;
    localparam logic [1:0] MODE_ALWAYS = 2'h3;
    localparam logic [1:0] MODE_RUN_ONLY = 2'h2;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [2:0] OSC_EXT_HIGH = 3'h7;
    localparam logic [2:0] OSC_EXT_MID = 3'h6;
    localparam logic [2:0] OSC_EXT_LOW = 3'h5;
    localparam logic [2:0] OSC_INTERNAL = 3'h4;
    localparam logic [2:0] OSC_EXT_RC = 3'h3;
    localparam logic [2:0] OSC_FAST_XTAL = 3'h2;
    localparam logic [2:0] OSC_STD_XTAL = 3'h1;
    localparam logic [2:0] OSC_LP_XTAL = 3'h0;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    localparam logic [3:0] FREQ_RESET = 4'h7;
    localparam logic [3:0] FREQ_SLOW = 4'h0;
    localparam logic [3:0] FREQ_PLL = 4'hf;
    localparam logic [1:0] SRC_CONFIG = 2'h0;
    localparam int STARTUP_COUNT = 1024;
    localparam logic [3:0] REG_CFG_ONE = 4'h0;
    localparam logic [3:0] REG_TRIM = 4'h1;
    localparam logic [3:0] REG_CONTROL = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam logic [3:0] REG_SOFT = 4'h4;
endpackage

// [src/edge_counter.sv]
// Counts falling edges of a sampled clock level up to a limit.
`timescale 1ns/10ps
`default_nettype none
module edge_counter
    import cfg_clk_pkg::*;
#(
    parameter int LIMIT = STARTUP_COUNT
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Control.
    input wire logic i_restart,
    input wire logic i_enable,
    input wire logic i_level,
    // Result.
    output logic o_done
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
    logic prev_q;
    logic [CW-1:0] count_q;

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            prev_q <= 1'b0;
        else
            prev_q <= i_level;
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            count_q <= '0;
        else if (i_restart)
            count_q <= '0;
        else if (i_enable && prev_q && !i_level && count_q != LIMIT_C)
            count_q <= count_q + CW'(1);
    end

    assign o_done = (count_q == LIMIT_C);

    a_count_bounded: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R20
        count_q <= LIMIT_C) else $error("start-up count passed its limit");
endmodule // edge_counter
`default_nettype wire

// [src/cfg_clock_select.sv]
// Configuration word decode and system clock selection with two-speed start-up.
//
// Summary of operation
// R01 - Config words held at 8007h and 8008h.
// R02 - Bit 13 enables failing-clock monitor.
// R03 - Bit 12 enables two-speed start-up.
// R04 - Bit 11 clock-out, ignored in crystal modes.
// R05 - Bits 10-9 select brown-out mode.
// R06 - Bits 8,7 low enable read protection.
// R07 - Protection turned off erases memory.
// R08 - Bit 6 reset pin, ignored under LOW_VOLTAGE_PROG.
// R09 - Bit 5 low enables power-up timer.
// R10 - Bits 4-3 select watchdog mode.
// R11 - Bits 2-0 select oscillator source.
// R12 - Tools keep debug bit at one.
// R13 - Six-bit signed trim, resets to zero.
// R14 - Trim drifts, no completion status.
// R15 - Trim never alters slow oscillator.
// R16 - Slow oscillator runs when selected or used.
// R17 - Status bit shows slow oscillator running.
// R18 - Four-bit field selects internal frequency.
// R19 - Every reset loads frequency field 0111.
// R20 - Run internal while counting 1024 cycles.
// R21 - Wait edges, set status, then switch.
// R22 - Software reads external-running status.
// R23 - Without switchover, crystal holds execution.
`timescale 1ns/10ps
`default_nettype none
module cfg_clock_select
    import cfg_clk_pkg::*;
#(
    parameter int START_CYCLES = STARTUP_COUNT
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Non-volatile configuration.
    input wire logic [15:0] i_cfg_addr,
    input wire logic [CFG_WIDTH-1:0] i_cfg_data,
    input wire logic i_cfg_load,
    input wire logic i_low_voltage_prog,
    input wire logic i_protect_erase,
    // Oscillator levels and events.
    input wire logic i_internal_osc,
    input wire logic i_ext_clock,
    input wire logic i_wake,
    input wire logic i_sleeping,
    // Decoded configuration.
    output logic o_failsafe_monitor_en,
    output logic o_clock_output_en,
    output logic o_brownout_active,
    output logic o_data_protect_n,
    output logic o_program_protect_n,
    output logic o_reset_pin_select,
    output logic o_pin_pullup_en,
    output logic o_powerup_timer_en,
    output logic o_watchdog_active,
    output logic [2:0] o_osc_select,
    output logic o_erase_program,
    output logic o_erase_data,
    // Clock control.
    output logic [5:0] o_trim,
    output logic [3:0] o_int_freq_select,
    output logic o_pll_en,
    output logic o_slow_osc_en,
    output logic o_use_external,
    output logic o_sysclk_hold,
    output logic o_exec_hold
);
    typedef enum logic [2:0] {ST_IDLE, ST_COUNT, ST_WAIT_INT, ST_WAIT_EXT, ST_EXTERNAL} start_t;

    function automatic logic is_crystal(input logic [2:0] sel);
        is_crystal = (sel == OSC_LP_XTAL) || (sel == OSC_STD_XTAL) || (sel == OSC_FAST_XTAL);
    endfunction

    function automatic logic mode_on(input logic [1:0] m, input logic sw, input logic sleep);
        case (m)
            MODE_ALWAYS: mode_on = 1'b1;
            MODE_RUN_ONLY: mode_on = !sleep;
            MODE_SOFTWARE: mode_on = sw;
            default: mode_on = 1'b0;
        endcase
    endfunction

    logic [CFG_WIDTH-1:0] cfg_one_q;
    logic [CFG_WIDTH-1:0] cfg_two_q;
    logic [5:0] trim_q;
    logic [3:0] freq_q;
    logic [1:0] src_q;
    logic sw_brownout_q;
    logic sw_watchdog_q;
    logic pin_pullup_q;
    start_t state_q;
    start_t state_d;
    logic int_prev_q;
    logic ext_prev_q;
    logic count_done;
    logic count_restart;
    logic int_fall;
    logic ext_fall;
    logic ext_running_q;
    logic slow_en_d;
    logic [2:0] osc;
    logic xtal;

    assign osc = cfg_one_q[OSC_HI:OSC_LO];
    assign xtal = is_crystal(osc);
    assign int_fall = int_prev_q && !i_internal_osc;
    assign ext_fall = ext_prev_q && !i_ext_clock;
    assign count_restart = i_wake;

    // Configuration words load from their program addresses.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cfg_one_q <= '1;
            cfg_two_q <= '1;
        end
        else if (i_cfg_load && i_cfg_addr == CFG_WORD_ONE_ADDR) // R01
            cfg_one_q <= i_cfg_data;
        else if (i_cfg_load && i_cfg_addr == CFG_WORD_TWO_ADDR) // R01
            cfg_two_q <= i_cfg_data;
    end

    // Software writable registers.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            trim_q <= TRIM_RESET;
            freq_q <= FREQ_RESET;
            src_q <= SRC_CONFIG;
            sw_brownout_q <= 1'b0;
            sw_watchdog_q <= 1'b0;
            pin_pullup_q <= 1'b0;
        end
        else if (i_wr)
        begin
            case (i_addr)
                REG_TRIM: trim_q <= i_wdata[5:0]; // R13
                REG_CONTROL:
                begin
                    freq_q <= i_wdata[5:2]; // R18
                    src_q <= i_wdata[1:0];
                end
                REG_SOFT:
                begin
                    sw_brownout_q <= i_wdata[0];
                    sw_watchdog_q <= i_wdata[1];
                    pin_pullup_q <= i_wdata[2];
                end
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= '0;
        else if (i_rd)
        begin
            case (i_addr)
                REG_CFG_ONE: o_rdata <= {2'h0, cfg_one_q};
                REG_TRIM: o_rdata <= {10'h000, trim_q}; // R14
                REG_CONTROL: o_rdata <= {10'h000, freq_q, src_q};
                REG_STATE: o_rdata <= {14'h0000, o_slow_osc_en, ext_running_q}; // R17 R22
                REG_SOFT: o_rdata <= {13'h0000, pin_pullup_q, sw_watchdog_q, sw_brownout_q};
                default: o_rdata <= '0;
            endcase
        end
        else
            o_rdata <= '0;
    end

    // Decoded option outputs.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_failsafe_monitor_en <= 1'b0;
            o_clock_output_en <= 1'b0;
            o_brownout_active <= 1'b0;
            o_data_protect_n <= 1'b1;
            o_program_protect_n <= 1'b1;
            o_reset_pin_select <= 1'b1;
            o_pin_pullup_en <= 1'b1;
            o_powerup_timer_en <= 1'b0;
            o_watchdog_active <= 1'b0;
            o_osc_select <= OSC_EXT_HIGH;
            o_erase_program <= 1'b0;
            o_erase_data <= 1'b0;
        end
        else
        begin
            o_failsafe_monitor_en <= cfg_one_q[FAILSAFE_BIT]; // R02
            o_clock_output_en <= !xtal && !cfg_one_q[CLOCK_OUT_PIN_BIT]; // R04
            o_brownout_active <= mode_on(cfg_one_q[BROWNOUT_HI:BROWNOUT_LO], sw_brownout_q, i_sleeping); // R05
            o_data_protect_n <= cfg_one_q[DATA_PROT_BIT]; // R06
            o_program_protect_n <= cfg_one_q[PROG_PROT_BIT]; // R06
            o_reset_pin_select <= i_low_voltage_prog || cfg_one_q[RESET_PIN_BIT]; // R08
            o_pin_pullup_en <= (i_low_voltage_prog || cfg_one_q[RESET_PIN_BIT]) ? 1'b1 : pin_pullup_q; // R08
            o_powerup_timer_en <= !cfg_one_q[POWERUP_BIT]; // R09
            o_watchdog_active <= mode_on(cfg_one_q[WATCHDOG_HI:WATCHDOG_LO], sw_watchdog_q, i_sleeping); // R10
            o_osc_select <= osc; // R11
            o_erase_program <= i_protect_erase && !cfg_one_q[PROG_PROT_BIT]; // R07
            o_erase_data <= i_protect_erase && !cfg_one_q[DATA_PROT_BIT]; // R07
        end
    end

    // Clock control outputs; trim goes only to the fast source.
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_trim <= TRIM_RESET;
            o_int_freq_select <= FREQ_RESET;
            o_pll_en <= 1'b0;
            o_slow_osc_en <= 1'b0;
        end
        else
        begin
            o_trim <= trim_q; // R13 R15
            o_int_freq_select <= freq_q; // R18 R19
            o_pll_en <= (freq_q == FREQ_PLL); // R18
            o_slow_osc_en <= slow_en_d; // R16
        end
    end

    assign slow_en_d = (freq_q == FREQ_SLOW && src_q[1])
        || !cfg_one_q[POWERUP_BIT] || cfg_one_q[FAILSAFE_BIT]
        || mode_on(cfg_one_q[WATCHDOG_HI:WATCHDOG_LO], sw_watchdog_q, i_sleeping);

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            int_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            int_prev_q <= i_internal_osc;
            ext_prev_q <= i_ext_clock;
        end
    end

    edge_counter #(
        .LIMIT(START_CYCLES)
    ) u_startup (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_restart(count_restart),
        .i_enable(state_q == ST_COUNT),
        .i_level(i_ext_clock),
        .o_done(count_done)
    );

    // Start-up sequencing.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (i_wake && xtal)
                    state_d = ST_COUNT;
            ST_COUNT:
                if (count_done)
                    state_d = cfg_one_q[SWITCHOVER_BIT] ? ST_WAIT_INT : ST_EXTERNAL; // R03 R20 R23
            ST_WAIT_INT:
                if (int_fall)
                    state_d = ST_WAIT_EXT; // R21
            ST_WAIT_EXT:
                if (ext_fall)
                    state_d = ST_EXTERNAL; // R21
            ST_EXTERNAL:
                if (i_wake)
                    state_d = xtal ? ST_COUNT : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            ext_running_q <= 1'b0;
        else if ((state_q == ST_WAIT_INT && int_fall) || (state_q == ST_COUNT && state_d == ST_EXTERNAL))
            ext_running_q <= 1'b1; // R21 R22
        else if (state_q == ST_COUNT)
            ext_running_q <= 1'b0;
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_use_external <= 1'b0;
            o_sysclk_hold <= 1'b0;
            o_exec_hold <= 1'b0;
        end
        else
        begin
            o_use_external <= (state_d == ST_EXTERNAL) || (state_d == ST_IDLE && !xtal && osc != OSC_INTERNAL); // R21
            o_sysclk_hold <= (state_d == ST_WAIT_EXT); // R21
            o_exec_hold <= (state_d == ST_COUNT) && !cfg_one_q[SWITCHOVER_BIT]; // R20 R23
        end
    end

    a_hold_no_switch: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R23
        (state_q == ST_COUNT && !cfg_one_q[SWITCHOVER_BIT]) |-> o_exec_hold)
        else $error("execution ran during start-up count without switchover");
    a_status_direct: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R22
        (state_q == ST_COUNT && count_done && !cfg_one_q[SWITCHOVER_BIT]) |=> ext_running_q && o_use_external)
        else $error("status not set on direct switch to external");
    a_status_before_ext: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R21
        (state_q == ST_WAIT_INT && int_fall) |=> ext_running_q && o_sysclk_hold)
        else $error("status not set on internal falling edge");
    a_freq_reset: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R19
        $rose(i_resetn) |-> o_int_freq_select == FREQ_RESET)
        else $error("frequency field not at reset value");
    a_clock_out_pin_xtal: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R04
        ($stable(cfg_one_q) && xtal) |=> !o_clock_output_en)
        else $error("clock-out driven in crystal mode");
    a_powerup_timer_decode: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R09
        1'b1 |=> o_powerup_timer_en == !$past(cfg_one_q[POWERUP_BIT]))
        else $error("power-up timer enable wrong");
    a_trim_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R13
        (i_wr && i_addr == REG_TRIM) |=> ##1 o_trim == $past(i_wdata[5:0], 2))
        else $error("trim not applied");
    a_fail_mon: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R02
        1'b1 |=> o_failsafe_monitor_en == $past(cfg_one_q[FAILSAFE_BIT]))
        else $error("monitor enable wrong");
    a_pll_select: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R18
        1'b1 |=> o_pll_en == ($past(freq_q) == FREQ_PLL))
        else $error("multiplier enable wrong");
endmodule // cfg_clock_select
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the configuration decoder and clock selector.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cfg_clk_pkg::*;
    localparam int NS = 8;
    typedef struct packed {logic [13:0] w; logic s; logic [2:0] sb; logic [11:0] e;} row_t;
    logic i_mclk = 1'h0, i_resetn = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_cfg_load = 1'h0, i_wake = 1'h0;
    logic i_sleeping = 1'h0, i_low_voltage_prog = 1'h0, i_protect_erase = 1'h0;
    logic i_internal_osc = 1'h0, i_ext_clock = 1'h0, seen;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0, i_cfg_addr = 16'h0, o_rdata, v;
    logic [13:0] i_cfg_data = 14'h0;
    logic [5:0] o_trim;
    logic [3:0] o_int_freq_select;
    logic [2:0] o_osc_select, cnt_q = 3'h0;
    logic o_failsafe_monitor_en, o_clock_output_en, o_brownout_active, o_data_protect_n;
    logic o_program_protect_n, o_reset_pin_select, o_pin_pullup_en, o_powerup_timer_en;
    logic o_watchdog_active, o_erase_program, o_erase_data, o_pll_en, o_slow_osc_en;
    logic o_use_external, o_sysclk_hold, o_exec_hold;
    int n_mismatch = 0, total_checks = 0, nfall = 0, base, k;
    logic [15:0] tv [3] = '{16'h001f, 16'h0020, 16'hffff};
    row_t rows [11] = '{
        '{14'h3fff, 1'h0, 3'h0, 12'hbef}, '{14'h0414, 1'h1, 3'h4, 12'h434},
        '{14'h0414, 1'h0, 3'h0, 12'h61c}, '{14'h33ea, 1'h0, 3'h3, 12'hbea},
        '{14'h33ea, 1'h0, 3'h0, 12'h9e2}, '{14'h0963, 1'h0, 3'h7, 12'h163},
        '{14'h37f8, 1'h0, 3'h0, 12'hbe8}, '{14'h37fd, 1'h0, 3'h0, 12'hfed},
        '{14'h37fe, 1'h0, 3'h0, 12'hfee}, '{14'h37f9, 1'h0, 3'h0, 12'hbe9},
        '{14'h37ff, 1'h0, 3'h0, 12'hfef}};

    always #2.5 i_mclk = ~i_mclk;

    // Oscillator levels: external period 4 cycles, internal period 8 cycles.
    always @(posedge i_mclk)
    begin
        cnt_q <= cnt_q + 3'h1;
        i_ext_clock <= cnt_q[1];
        i_internal_osc <= cnt_q[2];
        if (i_ext_clock && !cnt_q[1])
            nfall <= nfall + 1;
    end

    cfg_clock_select #(.START_CYCLES(NS)) i_cfg_clock_select (
        .i_mclk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_cfg_addr, .i_cfg_data, .i_cfg_load, .i_low_voltage_prog, .i_protect_erase,
        .i_internal_osc, .i_ext_clock, .i_wake, .i_sleeping,
        .o_failsafe_monitor_en, .o_clock_output_en, .o_brownout_active, .o_data_protect_n,
        .o_program_protect_n, .o_reset_pin_select, .o_pin_pullup_en, .o_powerup_timer_en,
        .o_watchdog_active, .o_osc_select, .o_erase_program, .o_erase_data,
        .o_trim, .o_int_freq_select, .o_pll_en, .o_slow_osc_en, .o_use_external,
        .o_sysclk_hold, .o_exec_hold
    );

    function automatic logic [11:0] dec();
        return {o_failsafe_monitor_en, o_clock_output_en, o_brownout_active, o_data_protect_n,
            o_program_protect_n, o_reset_pin_select, o_pin_pullup_en, o_powerup_timer_en,
            o_watchdog_active, o_osc_select};
    endfunction

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic to(input logic ok);
        if (!ok)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        cyc(1);
        i_wr <= 1'h0;
        cyc(1);
    endtask

    task automatic rd(input logic [3:0] a);
        i_addr <= a;
        i_rd <= 1'h1;
        cyc(1);
        i_rd <= 1'h0;
        v = o_rdata;
        cyc(1);
    endtask

    task automatic ld(input logic [15:0] a, input logic [13:0] d);
        i_cfg_addr <= a;
        i_cfg_data <= d;
        i_cfg_load <= 1'h1;
        cyc(1);
        i_cfg_load <= 1'h0;
        cyc(3);
    endtask

    task automatic wake();
        i_wake <= 1'h1;
        cyc(1);
        i_wake <= 1'h0;
        base = nfall;
        cyc(2);
    endtask

    initial
    begin
        cyc(3);
        i_resetn <= 1'h1;
        cyc(1);
        chk(o_trim, 16'h0);
        chk(o_int_freq_select, 16'h7);
        rd(4'h2);
        chk(v, 16'h001c);
        rd(4'h0);
        chk(v, 16'h3fff);
        endt("reset");
        foreach (rows[i])
        begin
            wr(4'h4, {13'h0, rows[i].sb});
            i_sleeping <= rows[i].s;
            ld(16'h8007, rows[i].w);
            chk({4'h0, dec()}, {4'h0, rows[i].e});
            rd(4'h0);
            chk(v, {2'h0, rows[i].w});
        end
        i_sleeping <= 1'h0;
        ld(16'h8008, 14'h3fff);
        chk({4'h0, dec()}, 16'h0fef);
        endt("decode");
        ld(16'h8007, 14'h3e7f);
        i_protect_erase <= 1'h1;
        cyc(3);
        chk({o_erase_program, o_erase_data}, 16'h3);
        i_protect_erase <= 1'h0;
        cyc(3);
        chk(o_erase_data, 16'h0);
        i_protect_erase <= 1'h1;
        ld(16'h8007, 14'h3fff);
        chk({o_erase_program, o_erase_data}, 16'h0);
        i_protect_erase <= 1'h0;
        endt("erase");
        ld(16'h8007, 14'h0963);
        for (int f = 0; f < 16; f++)
            for (int s = 0; s < 4; s += 2)
            begin
                wr(4'h2, 16'(f * 4 + s));
                rd(4'h2);
                chk(v, 16'(f * 4 + s));
                chk(o_int_freq_select, 16'(f));
                chk(o_pll_en, 16'(f == 15));
                chk(o_slow_osc_en, 16'(f == 0 && s == 2));
                rd(4'h3);
                chk(v[1], 16'(f == 0 && s == 2));
            end
        endt("frequency");
        wr(4'h2, 16'h0002);
        foreach (tv[i])
        begin
            wr(4'h1, tv[i]);
            rd(4'h1);
            chk(v, tv[i] & 16'h003f);
            chk(o_trim, tv[i] & 16'h003f);
            chk(o_slow_osc_en, 16'h1);
        end
        wr(4'h9, 16'hffff);
        rd(4'h9);
        chk(v, 16'h0);
        wr(4'h0, 16'h0);
        rd(4'h0);
        chk(v, 16'h0963);
        endt("trim");
        i_resetn <= 1'h0;
        cyc(2);
        i_resetn <= 1'h1;
        cyc(1);
        chk(o_trim, 16'h0);
        rd(4'h2);
        chk(v, 16'h001c);
        endt("second reset");
        ld(16'h8007, 14'h3ffa);
        wake();
        chk({o_use_external, o_exec_hold}, 16'h0);
        rd(4'h3);
        chk(v[0], 16'h0);
        seen = 1'h0;
        for (k = 0; k < 300 && o_use_external !== 1'h1; k++)
        begin
            if (o_sysclk_hold === 1'h1)
                seen = 1'h1;
            cyc(1);
        end
        to(k < 300);
        chk(seen, 16'h1);
        chk(16'(nfall - base >= NS), 16'h1);
        cyc(1);
        chk(o_sysclk_hold, 16'h0);
        rd(4'h3);
        chk(v[0], 16'h1);
        endt("two-speed");
        ld(16'h8007, 14'h2ff9);
        wake();
        chk(o_exec_hold, 16'h1);
        for (k = 0; k < 300 && o_exec_hold === 1'h1; k++)
            cyc(1);
        to(k < 300);
        chk(16'(nfall - base >= NS), 16'h1);
        cyc(2);
        chk(o_use_external, 16'h1);
        rd(4'h3);
        chk(v[0], 16'h1);
        ld(16'h8007, 14'h3ffc);
        wake();
        cyc(40);
        chk({o_use_external, o_exec_hold}, 16'h0);
        ld(16'h8007, 14'h3fff);
        chk(o_use_external, 16'h1);
        endt("start-up");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
